// *** include/rtcw_cfg.svh ***
// Function
// - time base from external 32.768 kHz crystal
// - prescaler divides crystal to one-second tick
// - cascaded seconds, minutes, hours, day counters
// - periodic flags on second/minute/hour/day rollover
// - enabled alarm flags when time equals alarm
// - alarm one time-of-day, alarm two day+time
// - stopwatch decrements once per second tick
// - enabled stopwatch underflow raises stopwatch flag
// - counting continues during processor low power
// - enabled events request wakeup from sleep
// - events also wake deep sleep, regulator
// - wakeup only when its mask bit set
`ifndef RTCW_CFG_SVH
`define RTCW_CFG_SVH

// timing
`define RTCW_XTAL_HZ    32768
`define RTCW_TICK_HZ    1
`define RTCW_HCLK_HZ    20000000

// register byte offsets (low address bits only)
`define RTCW_OFF_TIME   8'h00
`define RTCW_OFF_CTRL   8'h04
`define RTCW_OFF_STAT   8'h08
`define RTCW_OFF_ALM1   8'h0C
`define RTCW_OFF_ALM2   8'h10
`define RTCW_OFF_SWAT   8'h14
`define RTCW_OFF_WAKE   8'h18

// time word field positions
`define RTCW_SEC_LSB    0
`define RTCW_MIN_LSB    6
`define RTCW_HOUR_LSB   12
`define RTCW_DAY_LSB    17

// last value before each counter wraps
`define RTCW_SEC_LAST   6'h3B
`define RTCW_MIN_LAST   6'h3B
`define RTCW_HOUR_LAST  5'h17
`define RTCW_DAY_LAST   15'h7FFF

// flag and enable bit positions
`define RTCW_F_SEC      0
`define RTCW_F_MIN      1
`define RTCW_F_HOUR     2
`define RTCW_F_DAY      3
`define RTCW_F_ALM1     4
`define RTCW_F_ALM2     5
`define RTCW_F_SWAT     6

// wake mask bit positions
`define RTCW_W_SLEEP    0
`define RTCW_W_DEEP     1
`define RTCW_W_VREG     2

// reset values
`define RTCW_CTRL_RST   7'h00
`define RTCW_STAT_RST   7'h00
`define RTCW_WAKE_RST   3'h0

`endif

// *** include/rtcw_pkg.sv ***
`default_nettype none
package rtcw_pkg;
  typedef logic [5:0]  rtcw_sec_type;
  typedef logic [5:0]  rtcw_min_type;
  typedef logic [4:0]  rtcw_hour_type;
  typedef logic [14:0] rtcw_day_type;
  typedef logic [6:0]  rtcw_flag_type;
  typedef logic [2:0]  rtcw_wake_type;
  typedef enum logic [1:0] {
    RTCW_IDLE = 2'b00,
    RTCW_BUSY = 2'b01,
    RTCW_NSEQ = 2'b10,
    RTCW_SEQ  = 2'b11
  } rtcw_htrans_type;
endpackage
`default_nettype wire

// *** hdl/rtcw_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_cfg.svh"

module rtcw_prescaler
  import rtcw_pkg::*;
#(
  parameter int PRESCALE = `RTCW_XTAL_HZ / `RTCW_TICK_HZ
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // crystal pin and restart
  input  wire logic rtc_xtal,
  input  wire logic restart,
  // one-second pulse
  output logic      tick
);

  localparam int CW = $clog2(PRESCALE);

  // the crystal must be sampled well above twice its rate
  if (PRESCALE < 2 || `RTCW_HCLK_HZ < 4 * `RTCW_XTAL_HZ) begin : g_bad
    $error("rtcw_prescaler: unusable prescale or clock ratio");
  end

  logic          xtal_s1;  // first sync stage, read by s2 only
  logic          xtal_s2;  // second sync stage
  logic          xtal_d;   // previous synced level
  logic [CW-1:0] count;    // crystal edges in this second
  wire           xtal_rise = xtal_s2 & ~xtal_d;
  wire           last = (count == CW'(PRESCALE - 1));

  // crystal is asynchronous to hclk, two flops first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_d  <= 1'b0;
    end else begin
      xtal_s1 <= rtc_xtal;
      xtal_s2 <= xtal_s1;
      xtal_d  <= xtal_s2;
    end
  end

  // divide crystal edges down to one tick per second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      // time reload starts a fresh full second
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= xtal_rise & last;
      if (xtal_rise) begin
        count <= last ? '0 : count + CW'(1);
      end
    end
  end

  property p_tick_edge;
    @(posedge hclk) disable iff (!hresetn)
    tick |-> $past(xtal_rise);
  endproperty
  a_tick_edge: assert property (p_tick_edge)
    else $error("tick without crystal edge");

  property p_tick_single;
    @(posedge hclk) disable iff (!hresetn)
    tick |=> !tick [*2];
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("tick longer than one cycle");

endmodule
`default_nettype wire

// *** hdl/rtcw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_cfg.svh"

module rtcw_top
  import rtcw_pkg::*;
#(
  parameter int PRESCALE = `RTCW_XTAL_HZ / `RTCW_TICK_HZ, // edges/second
  parameter int SW_W     = 16                             // stopwatch bits
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // crystal pin
  input  wire logic        rtc_xtal,
  // event outputs
  output logic             rtc_irq,
  output logic             wake_sleep,
  output logic             wake_deep_sleep,
  output logic             wake_regulator
);

  // stopwatch must fit the 32-bit register word
  if (SW_W < 1 || SW_W > 32) begin : g_bad
    $error("rtcw_top: SW_W must be 1..32");
  end

  // timekeeping state
  rtcw_sec_type  sec;        // seconds 0..59
  rtcw_min_type  min;        // minutes 0..59
  rtcw_hour_type hour;       // hours 0..23
  rtcw_day_type  day;        // day count, 15 bits
  // software state
  rtcw_flag_type ctrl;       // per-source enables
  rtcw_flag_type stat;       // sticky flags
  logic [16:0]   alm1;       // time-of-day alarm
  logic [31:0]   alm2;       // day plus time alarm
  logic [SW_W-1:0] swatch;   // stopwatch count
  rtcw_wake_type wake_mask;  // wakeup_enable_mask
  // bus data phase
  logic          dp_wr;      // write data phase pending
  logic [7:0]    dp_addr;    // latched offset
  logic          tick;       // one-second pulse

  // bus decode
  wire       addr_ok = hsel & htrans[1] & hready;
  wire [7:0] rd_off  = haddr[7:0];
  wire       wr_time = dp_wr & (dp_addr == `RTCW_OFF_TIME);
  wire       wr_ctrl = dp_wr & (dp_addr == `RTCW_OFF_CTRL);
  wire       wr_stat = dp_wr & (dp_addr == `RTCW_OFF_STAT);
  wire       wr_alm1 = dp_wr & (dp_addr == `RTCW_OFF_ALM1);
  wire       wr_alm2 = dp_wr & (dp_addr == `RTCW_OFF_ALM2);
  wire       wr_swat = dp_wr & (dp_addr == `RTCW_OFF_SWAT);
  wire       wr_wake = dp_wr & (dp_addr == `RTCW_OFF_WAKE);

  // prescaler, counts crystal edges sampled on hclk
  // a time load restarts it, so the first second is a whole one
  rtcw_prescaler #(
    .PRESCALE (PRESCALE)
  ) u_presc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .rtc_xtal (rtc_xtal),
    .restart  (wr_time),
    .tick     (tick)
  );

  // carry chain, each stage rolls only when all below roll
  wire sec_wrap  = (sec == `RTCW_SEC_LAST);
  wire min_last  = (min == `RTCW_MIN_LAST);
  wire hour_last = (hour == `RTCW_HOUR_LAST);
  wire min_wrap  = sec_wrap & min_last;
  wire hour_wrap = min_wrap & hour_last;

  // next time values at the coming tick
  wire rtcw_sec_type  next_sec  =
    sec_wrap ? 6'h00 : sec + 6'h01;
  wire rtcw_min_type  next_min  =
    !sec_wrap ? min : (min_last ? 6'h00 : min + 6'h01);
  wire rtcw_hour_type next_hour =
    !min_wrap ? hour : (hour_last ? 5'h00 : hour + 5'h01);
  // day rolls from all ones to zero by plain overflow
  wire rtcw_day_type  next_day  =
    hour_wrap ? day + 15'h0001 : day;
  wire [16:0] next_tod  = {next_hour, next_min, next_sec};
  wire [31:0] next_full = {next_day, next_tod};
  wire [31:0] time_word = {day, hour, min, sec};

  // alarm compare against the value the tick will load
  wire alm1_hit = tick & ctrl[`RTCW_F_ALM1] &
                  (next_tod == alm1);
  wire alm2_hit = tick & ctrl[`RTCW_F_ALM2] &
                  (next_full == alm2);

  // stopwatch counts only while enabled
  wire sw_dec   = tick & ctrl[`RTCW_F_SWAT];
  wire sw_under = sw_dec & (swatch == '0);

  // event vector, one bit per flag
  wire rtcw_flag_type evt = {
    sw_under,
    alm2_hit,
    alm1_hit,
    tick & hour_wrap,
    tick & min_wrap,
    tick & sec_wrap,
    tick
  };

  // write-one-to-clear; a new event wins over the clear
  wire rtcw_flag_type clr_mask  = wr_stat ? hwdata[6:0] : 7'h00;
  wire rtcw_flag_type next_stat = (stat & ~clr_mask) | evt;
  wire                irq_any   = |(stat & ctrl);

  // read selection, unmapped offsets read zero
  wire [31:0] rd_data =
    (rd_off == `RTCW_OFF_TIME) ? time_word :
    (rd_off == `RTCW_OFF_CTRL) ? {25'h0000000, ctrl} :
    (rd_off == `RTCW_OFF_STAT) ? {25'h0000000, stat} :
    (rd_off == `RTCW_OFF_ALM1) ? {15'h0000, alm1} :
    (rd_off == `RTCW_OFF_ALM2) ? alm2 :
    (rd_off == `RTCW_OFF_SWAT) ? 32'(swatch) :
    (rd_off == `RTCW_OFF_WAKE) ? {29'h00000000, wake_mask} :
    32'h00000000;

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture; read data sampled here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      dp_wr <= addr_ok & hwrite;
      if (addr_ok) begin
        dp_addr <= haddr[7:0];
      end
      if (addr_ok & !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  // time counters; a software load wins over a tick
  // no low-power input exists, so sleep never stops them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec  <= 6'h00;
      min  <= 6'h00;
      hour <= 5'h00;
      day  <= 15'h0000;
    end else if (wr_time) begin
      sec  <= hwdata[`RTCW_SEC_LSB +: 6];
      min  <= hwdata[`RTCW_MIN_LSB +: 6];
      hour <= hwdata[`RTCW_HOUR_LSB +: 5];
      day  <= hwdata[`RTCW_DAY_LSB +: 15];
    end else if (tick) begin
      sec  <= next_sec;
      min  <= next_min;
      hour <= next_hour;
      day  <= next_day;
    end
  end

  // control, alarm and wake registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= `RTCW_CTRL_RST;
      alm1      <= 17'h00000;
      alm2      <= 32'h00000000;
      wake_mask <= `RTCW_WAKE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[6:0];
      end
      if (wr_alm1) begin
        alm1 <= hwdata[16:0];
      end
      if (wr_alm2) begin
        alm2 <= hwdata;
      end
      if (wr_wake) begin
        wake_mask <= hwdata[2:0];
      end
    end
  end

  // sticky status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat <= `RTCW_STAT_RST;
    end else begin
      stat <= next_stat;
    end
  end

  // stopwatch; underflow wraps to all ones and keeps going
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swatch <= '0;
    end else if (wr_swat) begin
      swatch <= hwdata[SW_W-1:0];
    end else if (sw_dec) begin
      swatch <= swatch - SW_W'(1);
    end
  end

  // interrupt and wake requests, one cycle behind the flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtc_irq         <= 1'b0;
      wake_sleep      <= 1'b0;
      wake_deep_sleep <= 1'b0;
      wake_regulator  <= 1'b0;
    end else begin
      rtc_irq         <= irq_any;
      wake_sleep      <= irq_any & wake_mask[`RTCW_W_SLEEP];
      wake_deep_sleep <= irq_any & wake_mask[`RTCW_W_DEEP];
      wake_regulator  <= irq_any & wake_mask[`RTCW_W_VREG];
    end
  end

  // checks
  property p_sec_wrap;
    @(posedge hclk) disable iff (!hresetn)
    tick && sec_wrap && !wr_time |=> sec == 6'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("seconds did not wrap");

  property p_min_carry;
    @(posedge hclk) disable iff (!hresetn)
    tick && sec_wrap && !min_last && !wr_time
      |=> min == $past(min) + 6'h01;
  endproperty
  a_min_carry: assert property (p_min_carry)
    else $error("minute carry missing");

  property p_sec_hold;
    @(posedge hclk) disable iff (!hresetn)
    !tick && !wr_time |=> $stable(sec) && $stable(day);
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("time moved without tick");

  property p_day_wrap;
    @(posedge hclk) disable iff (!hresetn)
    tick && hour_wrap && day == `RTCW_DAY_LAST && !wr_time
      |=> day == 15'h0000 && hour == 5'h00;
  endproperty
  a_day_wrap: assert property (p_day_wrap)
    else $error("day did not wrap");

  property p_min_flag;
    @(posedge hclk) disable iff (!hresetn)
    tick && sec_wrap |=> stat[`RTCW_F_MIN] && stat[`RTCW_F_SEC];
  endproperty
  a_min_flag: assert property (p_min_flag)
    else $error("minute flag not set");

  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
    !wr_stat |=> &(stat | ~$past(stat));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

  // a control write in the hit cycle may close the line again
  property p_alm1;
    @(posedge hclk) disable iff (!hresetn)
    tick && ctrl[`RTCW_F_ALM1] && next_tod == alm1 && !wr_ctrl
      |=> stat[`RTCW_F_ALM1] ##1 rtc_irq;
  endproperty
  a_alm1: assert property (p_alm1)
    else $error("alarm one missed");

  // a load of time or alarm in the hit cycle hides the match
  property p_alm2_cause;
    @(posedge hclk) disable iff (!hresetn)
    $rose(stat[`RTCW_F_ALM2]) && $past(!wr_time && !wr_alm2)
      |-> $past(tick && time_word != alm2)
      && time_word == alm2;
  endproperty
  a_alm2_cause: assert property (p_alm2_cause)
    else $error("alarm two without day and time match");

  property p_sw_dec;
    @(posedge hclk) disable iff (!hresetn)
    sw_dec && !wr_swat |=> swatch == $past(swatch) - SW_W'(1);
  endproperty
  a_sw_dec: assert property (p_sw_dec)
    else $error("stopwatch did not count down");

  property p_sw_under;
    @(posedge hclk) disable iff (!hresetn)
    sw_under && !wr_swat |=> stat[`RTCW_F_SWAT] && swatch == '1;
  endproperty
  a_sw_under: assert property (p_sw_under)
    else $error("stopwatch underflow missed");

  property p_wake_mask;
    @(posedge hclk) disable iff (!hresetn)
    !wake_mask[`RTCW_W_SLEEP] && !wr_wake |=> ##1 !wake_sleep;
  endproperty
  a_wake_mask: assert property (p_wake_mask)
    else $error("wake without mask bit");

  property p_wake_deep;
    @(posedge hclk) disable iff (!hresetn)
    wake_deep_sleep |-> rtc_irq && $past(wake_mask[`RTCW_W_DEEP]);
  endproperty
  a_wake_deep: assert property (p_wake_deep)
    else $error("deep-sleep wake without event");

  // the line follows the enabled flags, one cycle late
  property p_irq_gate;
    @(posedge hclk) disable iff (!hresetn)
    rtc_irq == $past(|(stat & ctrl));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt line disagrees with flags");

  c_alm2: cover property (@(posedge hclk) disable iff (!hresetn)
    alm2_hit);
  c_sw_under: cover property (@(posedge hclk) disable iff (!hresetn)
    sw_under);
  c_day_roll: cover property (@(posedge hclk) disable iff (!hresetn)
    tick && hour_wrap);
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    wake_sleep && wake_regulator);

endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_cfg.svh"

module tb_top
  import rtcw_pkg::*;
;
  // clock and reset
  logic        hclk = 1'b0;     // 20 MHz bus clock
  logic        hresetn;         // active-low reset
  // ahb-lite master side
  logic        hsel;            // slave select
  logic [31:0] haddr;           // byte address
  logic [1:0]  htrans;          // transfer type
  logic        hwrite;          // write strobe
  logic [2:0]  hsize;           // always a word
  logic [31:0] hwdata;          // write data
  wire logic   hreadyout;       // slave ready
  wire logic   hresp;           // always okay
  wire logic [31:0] hrdata;     // read data
  // crystal and events
  logic        rtc_xtal;        // slow crystal square wave
  logic [2:0]  xcnt;            // crystal divider
  wire logic   rtc_irq;         // combined interrupt
  wire logic   wake_sleep;      // wake from sleep
  wire logic   wake_deep_sleep; // wake from deep sleep
  wire logic   wake_regulator;  // restart regulator
  // bookkeeping
  int          err_count;       // mismatches seen
  int          compares;        // comparisons made
  int          n;               // cycles waited

  // prescale of 4 keeps one second at 32 bus cycles
  rtcw_top #(
    .PRESCALE (4),
    .SW_W     (16)
  ) u_dut (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hready          (hreadyout),
    .hwdata          (hwdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .hrdata          (hrdata),
    .rtc_xtal        (rtc_xtal),
    .rtc_irq         (rtc_irq),
    .wake_sleep      (wake_sleep),
    .wake_deep_sleep (wake_deep_sleep),
    .wake_regulator  (wake_regulator)
  );

  // bus clock, 50 ns period
  always #25 hclk = ~hclk;

  // crystal at hclk/8, well under the hclk/4 limit; quiet in reset
  always @(posedge hclk) begin
    if (!hresetn) begin
      xcnt     <= 3'h0;
      rtc_xtal <= 1'b0;
    end else begin
      xcnt     <= xcnt + 3'h1;
      rtc_xtal <= xcnt[2];
    end
  end

  // verdict and end of run
  task automatic end_sim;
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // wait for hready at a rising edge, bounded
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    err_count++;
    end_sim();
  endtask

  // single word transfer: address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= RTCW_NSEQ;
    hwrite <= wr;
    wait_rdy();
    // address taken: idle the bus, drive write data
    htrans <= RTCW_IDLE;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // register read, masked compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
    // the slave never answers with an error
    chk({31'h0, hresp}, 32'h0);
  endtask

  // wait for the interrupt line, bounded
  task automatic wait_irq(input int lim, output int c);
    for (c = 0; c < lim; c++) begin
      @(posedge hclk);
      if (rtc_irq === 1'b1)
        return;
    end
    err_count++;
    end_sim();
  endtask

  // time word from its fields
  function automatic logic [31:0] tm(input logic [14:0] d,
    input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
    return {d, h, m, s};
  endfunction

  // event outputs packed for one compare
  function automatic logic [31:0] outs();
    return {28'h000_0000, rtc_irq, wake_regulator, wake_deep_sleep,
            wake_sleep};
  endfunction

  // main sequence
  initial begin
    err_count = 0;
    compares  = 0;
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0000_0000;
    htrans    = RTCW_IDLE;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0000_0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped offset reads zero
    rd_chk(`RTCW_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    rd_chk(`RTCW_OFF_STAT, 32'hFFFF_FFFF, 32'h0);
    rd_chk(`RTCW_OFF_WAKE, 32'hFFFF_FFFF, 32'h0);
    rd_chk(8'h1C, 32'hFFFF_FFFF, 32'h0);
    chk(outs(), 32'h0);
    // full rollover from the last day, hour, minute, second
    wr(`RTCW_OFF_CTRL, 32'h0);
    wr(`RTCW_OFF_TIME, tm(15'h7FFF, 5'h17, 6'h3B, 6'h3B));
    wr(`RTCW_OFF_STAT, 32'h7F);
    wr(`RTCW_OFF_CTRL, 32'h0F);
    wait_irq(100, n);
    chk({31'h0, n >= 12 && n <= 44}, 32'h1);
    rd_chk(`RTCW_OFF_STAT, 32'h0F, 32'h0F);
    rd_chk(`RTCW_OFF_TIME, 32'hFFFF_FFFF, 32'h0);
    chk(outs(), 32'h8);
    // all mask bits open all wake lines; bit 1 alone opens only its own
    wr(`RTCW_OFF_WAKE, 32'h7);
    repeat (2) @(posedge hclk);
    chk(outs(), 32'hF);
    wr(`RTCW_OFF_WAKE, 32'h2);
    repeat (2) @(posedge hclk);
    chk(outs(), 32'hA);
    // flags stay sticky but the line stays low when disabled
    wr(`RTCW_OFF_CTRL, 32'h0);
    wr(`RTCW_OFF_STAT, 32'h7F);
    repeat (40) @(posedge hclk);
    chk(outs(), 32'h0);
    rd_chk(`RTCW_OFF_STAT, 32'h01, 32'h01);
    // wake lines were up, yet two more seconds were counted
    rd_chk(`RTCW_OFF_TIME, 32'hFFFF_FFFF, 32'h2);
    wr(`RTCW_OFF_WAKE, 32'h0);
    // first alarm ignores the day, second one needs it
    wr(`RTCW_OFF_TIME, tm(15'h2, 5'h0, 6'h0, 6'h5));
    wr(`RTCW_OFF_ALM1, tm(15'h0, 5'h0, 6'h0, 6'h7));
    wr(`RTCW_OFF_ALM2, tm(15'h9, 5'h0, 6'h0, 6'h7));
    wr(`RTCW_OFF_STAT, 32'h7F);
    wr(`RTCW_OFF_CTRL, 32'h30);
    wait_irq(200, n);
    rd_chk(`RTCW_OFF_STAT, 32'h30, 32'h10);
    rd_chk(`RTCW_OFF_TIME, 32'hFFFF_FFFF, tm(15'h2, 5'h0, 6'h0, 6'h7));
    wr(`RTCW_OFF_CTRL, 32'h0);
    wr(`RTCW_OFF_TIME, tm(15'h9, 5'h0, 6'h0, 6'h5));
    wr(`RTCW_OFF_STAT, 32'h7F);
    wr(`RTCW_OFF_CTRL, 32'h30);
    wait_irq(200, n);
    rd_chk(`RTCW_OFF_STAT, 32'h30, 32'h30);
    // disabled alarms never flag
    wr(`RTCW_OFF_CTRL, 32'h0);
    wr(`RTCW_OFF_TIME, tm(15'h9, 5'h0, 6'h0, 6'h5));
    wr(`RTCW_OFF_STAT, 32'h7F);
    repeat (120) @(posedge hclk);
    rd_chk(`RTCW_OFF_STAT, 32'h30, 32'h0);
    // stopwatch from 2: flag only on the third tick, then wraps
    wr(`RTCW_OFF_SWAT, 32'h2);
    wr(`RTCW_OFF_STAT, 32'h7F);
    wr(`RTCW_OFF_CTRL, 32'h40);
    wait_irq(200, n);
    chk({31'h0, n > 60 && n <= 110}, 32'h1);
    rd_chk(`RTCW_OFF_STAT, 32'h40, 32'h40);
    rd_chk(`RTCW_OFF_SWAT, 32'h0000_FFFF, 32'h0000_FFFF);
    end_sim();
  end
endmodule
`default_nettype wire
